/* File: gptc_cap_ch.sv */
// one capture channel: edge detect on its combined input, latch of the count
// assumes the input is synchronous to the clock
`timescale 1ns/100ps
`default_nettype none
module gptc_cap_ch
  import gptc_pkg::*;
#(
  parameter int W = 32
) (
  input  wire logic          clk,
  input  wire logic          arst_n,
  input  wire logic          sig_in,    // combined capture signal
  input  wire gptc_cap_cfg_s cfg,       // edge selection and irq enable
  input  wire logic [W-1:0]  count,     // current counter value
  input  wire logic          irq_clr,   // software clear of flag
  output logic      [W-1:0]  value,     // captured value
  output logic               irq_flag   // sticky capture flag
);

  logic sig_d_reg;  // delayed signal for edge detect
  logic fire;       // capture event this cycle

  // ==========================================================
  // edge detection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sig_d_reg <= 1'b0;
    end else begin
      sig_d_reg <= sig_in;
    end
  end

  assign fire = (cfg.on_rise & sig_in & ~sig_d_reg) |
                (cfg.on_fall & ~sig_in & sig_d_reg);

  // ==========================================================
  // latch and flag
  // latch counter value
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      value <= '0;
    end else if (fire) begin
      value <= count;
    end
  end

  // optional capture interrupt, set wins over clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_flag <= 1'b0;
    end else if (fire && cfg.irq_en) begin
      irq_flag <= 1'b1;
    end else if (irq_clr) begin
      irq_flag <= 1'b0;
    end
  end

endmodule : gptc_cap_ch
`default_nettype wire

/* File: gptc_pin_src.sv */
// external event source driving the eight capture pins
// assumes the bench sets event levels just after a clock edge
`timescale 1ns/100ps
`default_nettype none
module gptc_pin_src (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       ext_run,  // run the counting clock on pin 0
  input  wire logic [7:0] evt,      // levels for the event pins
  output logic      [7:0] pins      // capture pins of the timer
);
  logic [1:0] ph_reg;  // counting clock phase, idles low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ph_reg <= 2'h0;
    end else if (ext_run) begin
      ph_reg <= ph_reg + 2'h1;
    end
  end
  assign pins = evt ^ {7'h0, ph_reg[1]};
endmodule : gptc_pin_src
`default_nettype wire

/* File: gptc_pkg.sv */
// package for the general purpose timer/counter
// assumes one system clock; all control bits arrive as plain ports
package gptc_pkg;

  // ==========================================================
  // sizes
  localparam int GPTC_NUM_CH    = 4;   // capture and match channels
  localparam int GPTC_CNT_W     = 32;  // counter and prescaler width
  localparam int GPTC_SYNC_LEN  = 2;   // pin input stages, unused: pins enter the design with no stage

  // ==========================================================
  // reset values
  localparam logic [31:0] GPTC_CNT_RST   = 32'h0000_0000;
  localparam logic [31:0] GPTC_PRE_RST   = 32'h0000_0000;
  localparam logic [3:0]  GPTC_MOUT_RST  = 4'h0;

  // ==========================================================
  // encodings
  // counting source
  typedef enum logic [1:0] {
    GPTC_SRC_PCLK,
    GPTC_SRC_RISE,
    GPTC_SRC_FALL,
    GPTC_SRC_BOTH
  } gptc_src_e;

  // match output action
  typedef enum logic [1:0] {
    GPTC_OUT_KEEP,
    GPTC_OUT_LOW,
    GPTC_OUT_HIGH,
    GPTC_OUT_TOGGLE
  } gptc_out_e;

  // per-channel capture control
  typedef struct packed {
    logic on_rise;  // capture on rising edge
    logic on_fall;  // capture on falling edge
    logic irq_en;   // interrupt on capture
  } gptc_cap_cfg_s;

  // per-channel match control
  typedef struct packed {
    logic      irq_en;  // interrupt on match
    logic      reset;   // reset counter on match
    logic      stop;    // stop counter on match
    gptc_out_e action;  // external output action
  } gptc_mat_cfg_s;

endpackage : gptc_pkg

/* File: gptc_sva.sv */
// checker on the timer/counter top ports
// assumes one clock domain with async active-low reset
`timescale 1ns/100ps
`default_nettype none
module gptc_sva
  import gptc_pkg::*;
#(
  parameter int NCH = 4,
  parameter int W   = 32
) (
  input wire logic           SYS_CLK,
  input wire logic           ARST_N,
  input wire logic           CNT_ENABLE,
  input wire logic           CNT_RESET,
  input wire gptc_src_e      CNT_SOURCE,
  input wire logic [W-1:0]   PRESCALE,
  input wire logic [NCH-1:0] CAP_IRQ_CLR,
  input wire logic [W-1:0]   COUNT,
  input wire logic [W-1:0]   PRESCALE_COUNT,
  input wire logic [NCH-1:0] CAP_IRQ_FLAG,
  input wire logic [NCH-1:0] MAT_IRQ_FLAG,
  input wire logic           IRQ,
  input wire logic           STOPPED
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  // ==========================================
  // counting
  logic run;  // system clock counting allowed
  assign run = CNT_ENABLE && !STOPPED && !CNT_RESET && CNT_SOURCE == GPTC_SRC_PCLK;
  sequence s_tick;  // prescaler at its terminal value
    run && PRESCALE_COUNT == PRESCALE;
  endsequence
  sequence s_mid;  // prescaler still counting up
    run && PRESCALE_COUNT < PRESCALE;
  endsequence
  property p_tick;
    s_tick |=> COUNT == $past(COUNT) + 32'h1 || COUNT == '0 || STOPPED;
  endproperty
  a_tick: assert property (p_tick) else $error("count step wrong");
  property p_wrap;
    s_tick |=> PRESCALE_COUNT == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("prescaler no restart");
  property p_mid;
    s_mid |=> PRESCALE_COUNT == $past(PRESCALE_COUNT) + 32'h1 && $stable(COUNT);
  endproperty
  a_mid: assert property (p_mid) else $error("prescaler step wrong");
  property p_rst;
    CNT_RESET |=> COUNT == '0 && PRESCALE_COUNT == '0 && !STOPPED;
  endproperty
  a_rst: assert property (p_rst) else $error("counter reset ignored");
  property p_idle;
    !CNT_ENABLE && !CNT_RESET |=> $stable(COUNT);
  endproperty
  a_idle: assert property (p_idle) else $error("count moved disabled");
  property p_stop;
    STOPPED && !CNT_RESET |=> STOPPED && $stable(COUNT);
  endproperty
  a_stop: assert property (p_stop) else $error("stopped count moved");
  // ==========================================
  // interrupts
  property p_irq;
    IRQ == (|{CAP_IRQ_FLAG, MAT_IRQ_FLAG});
  endproperty
  a_irq: assert property (p_irq) else $error("irq not flag or");
  property p_sticky;
    CAP_IRQ_FLAG[0] && !CAP_IRQ_CLR[0] |=> CAP_IRQ_FLAG[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("capture flag lost");
endmodule : gptc_sva
bind gptc_top gptc_sva #(.NCH(NCH), .W(W)) u_sva (
  .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .CNT_ENABLE(CNT_ENABLE), .CNT_RESET(CNT_RESET),
  .CNT_SOURCE(CNT_SOURCE), .PRESCALE(PRESCALE), .CAP_IRQ_CLR(CAP_IRQ_CLR), .COUNT(COUNT),
  .PRESCALE_COUNT(PRESCALE_COUNT), .CAP_IRQ_FLAG(CAP_IRQ_FLAG),
  .MAT_IRQ_FLAG(MAT_IRQ_FLAG), .IRQ(IRQ), .STOPPED(STOPPED)
);
`default_nettype wire

/* File: gptc_tb_top.sv */
// self-checking bench for the timer/counter
// assumes the pin source model drives all capture pins
`timescale 1ns/100ps
`default_nettype none
module gptc_tb_top
  import gptc_pkg::*;
;
  logic clk = 1'h0, arst_n = 1'h0, en = 1'h0, crst = 1'h0, ext_run = 1'h0, irq, stopped;
  gptc_src_e src = GPTC_SRC_PCLK;
  logic [31:0] pre = 32'h0, cnt, pcnt;
  logic [7:0] evt = 8'h0, pins;
  logic [1:0] csel = 2'h0;  // which combined capture signal clocks the counter
  logic [3:0] cclr = 4'h0, mclr = 4'h0, cflag, mflag, mout;
  gptc_cap_cfg_s [3:0] cap_cfg = {3'h5, 3'h7, 3'h3, 3'h5};  // rise, both, fall, rise
  gptc_mat_cfg_s [3:0] mat_cfg = '0;
  logic [127:0] mval = {4{32'h4}}, capv;
  int err_total = 0, check_count = 0;
  always #25 clk = ~clk;
  gptc_top dut (
    .SYS_CLK(clk), .ARST_N(arst_n), .CNT_ENABLE(en), .CNT_RESET(crst), .CNT_SOURCE(src),
    .CLK_CAP_SEL(csel), .PRESCALE(pre), .CAPTURE_INPUT_PIN(pins), .CAP_PIN_EN(8'hFF),
    .CAP_AND_MODE(4'h8), .CAP_CFG(cap_cfg), .MAT_CFG(mat_cfg), .MATCH_VALUE(mval),
    .CAP_IRQ_CLR(cclr), .MAT_IRQ_CLR(mclr), .COUNT(cnt), .PRESCALE_COUNT(pcnt),
    .CAPTURE_VALUE(capv), .CAP_IRQ_FLAG(cflag), .MAT_IRQ_FLAG(mflag), .IRQ(irq),
    .MATCH_OUT(mout), .STOPPED(stopped)
  );
  gptc_pin_src u_src (.clk(clk), .arst_n(arst_n), .ext_run(ext_run), .evt(evt), .pins(pins));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic chk(input string nm, input logic [127:0] exp, input logic [127:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  // zero count and flags, then enable counting
  task automatic restart(input gptc_src_e s, input logic [31:0] p);
    en = 1'h0;
    crst = 1'h1;
    cclr = 4'hF;
    mclr = 4'hF;
    src = s;
    pre = p;
    step(1);
    crst = 1'h0;
    cclr = 4'h0;
    mclr = 4'h0;
    en = 1'h1;
  endtask : restart
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (4) @(posedge clk);
    #1 arst_n = 1'h1;
    restart(GPTC_SRC_PCLK, 32'h2);
    step(9);
    chk("count", 128'h3, cnt);
    chk("prescale_count", 128'h0, pcnt);
    $display("end prescaler");
    // all irq on; ch0 reset and keep, ch1 low, ch2 high, ch3 toggle
    mat_cfg = {5'h13, 5'h12, 5'h11, 5'h18};
    restart(GPTC_SRC_PCLK, 32'h0);
    step(7);
    chk("match_out", 128'hC, mout);
    chk("match_flag", 128'hF, mflag);
    step(5);
    chk("match_out", 128'h4, mout);
    chk("count", 128'h2, cnt);
    mclr = 4'hF;
    step(1);
    chk("match_flag", 128'h0, mflag);
    // only ch0 stops on match
    mat_cfg = 20'h00004;
    mval[31:0] = 32'h3;
    restart(GPTC_SRC_PCLK, 32'h0);
    step(8);
    chk("count", 128'h3, cnt);
    chk("stopped", 128'h1, stopped);
    mat_cfg[0].stop = 1'h0;
    $display("end match");
    restart(GPTC_SRC_PCLK, 32'h0);
    step(5);
    en = 1'h0;
    evt = 8'hFF;
    step(4);
    chk("capture", {32'h5, 32'h5, 32'h0, 32'h5}, capv);
    chk("cap_flag", 128'hD, cflag);
    chk("irq", 128'h1, irq);
    en = 1'h1;
    step(3);
    en = 1'h0;
    evt = 8'h80;
    step(4);
    chk("capture", {32'h5, 32'h8, 32'h8, 32'h5}, capv);
    evt = 8'hC0;
    step(4);
    chk("capture", {32'h8, 32'h8, 32'h8, 32'h5}, capv);
    $display("end capture");
    for (int k = 1; k < 4; k++) begin
      restart(gptc_src_e'(k), 32'h0);
      ext_run = 1'h1;
      step(16);
      ext_run = 1'h0;
      step(4);
      chk("ext_count", (k == 3) ? 128'h8 : 128'h4, cnt);
      evt = evt ^ 8'h10;
      step(4);
      chk("side_capture", (k == 3) ? 128'h8 : 128'h4, capv[95:64]);
    end
    // clock pin toggles but channel 1 is the selected clock: no count
    csel = 2'h1;
    restart(GPTC_SRC_RISE, 32'h0);
    ext_run = 1'h1;
    step(16);
    ext_run = 1'h0;
    step(4);
    chk("unselected_clock", 128'h0, cnt);
    csel = 2'h0;
    $display("end external clock");
    summarize();
  end
  // hang guard
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    summarize();
  end
endmodule : gptc_tb_top
`default_nettype wire

/* File: gptc_top.sv */
// general purpose 32-bit timer/counter with prescaler, capture and match
// assumes pins synchronous to SYS_CLK; controls are plain ports held by software
//
// Notes on behaviour
// - 32-bit counter behind 32-bit prescaler
// - count system clock or external clock
// - four channels latch count on transitions
// - per-channel optional capture interrupt
// - four matches: continue, stop or reset
// - match outputs low, high, toggle, keep
// - external clock from one capture input
// - other capture inputs keep working normally
// - pin groups combine by or, and
`timescale 1ns/100ps
`default_nettype none
module gptc_top
  import gptc_pkg::*;
#(
  parameter int NCH = GPTC_NUM_CH,  // channels
  parameter int W   = GPTC_CNT_W,   // counter width
  parameter int NP  = 2             // pins per capture channel
) (
  input  wire logic                  SYS_CLK,
  input  wire logic                  ARST_N,
  input  wire logic                  CNT_ENABLE,
  input  wire logic                  CNT_RESET,
  input  wire gptc_src_e             CNT_SOURCE,
  input  wire logic [1:0]            CLK_CAP_SEL,
  input  wire logic [W-1:0]          PRESCALE,
  input  wire logic [NCH*NP-1:0]     CAPTURE_INPUT_PIN,
  input  wire logic [NCH*NP-1:0]     CAP_PIN_EN,
  input  wire logic [NCH-1:0]        CAP_AND_MODE,
  input  wire gptc_cap_cfg_s [NCH-1:0] CAP_CFG,
  input  wire gptc_mat_cfg_s [NCH-1:0] MAT_CFG,
  input  wire logic [NCH*W-1:0]      MATCH_VALUE,
  input  wire logic [NCH-1:0]        CAP_IRQ_CLR,
  input  wire logic [NCH-1:0]        MAT_IRQ_CLR,
  output logic      [W-1:0]          COUNT,
  output logic      [W-1:0]          PRESCALE_COUNT,
  output logic      [NCH*W-1:0]      CAPTURE_VALUE,
  output logic      [NCH-1:0]        CAP_IRQ_FLAG,
  output logic      [NCH-1:0]        MAT_IRQ_FLAG,
  output logic                       IRQ,
  output logic      [NCH-1:0]        MATCH_OUT,
  output logic                       STOPPED
);

  // ==========================================================
  // declarations
  logic [W-1:0]   cnt_reg;      // main counter
  logic [W-1:0]   pre_reg;      // prescaler counter
  logic           stop_reg;     // stopped by a match
  logic [NCH-1:0] mout_reg;     // match output levels
  logic [NCH-1:0] mirq_reg;     // match flags
  logic [NCH-1:0] cap_sig;      // combined capture signals
  logic           ext_lvl;      // selected external clock level
  logic           ext_d_reg;    // delayed external level
  logic           src_tick;     // one source clock cycle
  logic           pre_wrap;     // prescaler wrapped
  logic [NCH-1:0] hit;          // match equality
  logic           any_reset;    // some match resets counter
  logic           any_stop;     // some match stops counter
  logic           running;      // counter is advancing

  // ==========================================================
  // pin combination per channel
  // or and and of pin groups
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      logic [NP-1:0] en;
      logic [NP-1:0] pins;
      en   = CAP_PIN_EN[c*NP +: NP];
      pins = CAPTURE_INPUT_PIN[c*NP +: NP];
      if (CAP_AND_MODE[c]) begin
        // and: every enabled pin high, unused pins count as high
        cap_sig[c] = &(pins | ~en) & (|en);
      end else begin
        // or: any enabled pin high
        cap_sig[c] = |(pins & en);
      end
    end
  end

  // ==========================================================
  // external clock selection
  // one capture input as clock
  assign ext_lvl = cap_sig[CLK_CAP_SEL];

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ext_d_reg <= 1'b0;
    end else begin
      ext_d_reg <= ext_lvl;
    end
  end

  // source selection, edges seen by sampling
  always_comb begin
    case (CNT_SOURCE)
      GPTC_SRC_PCLK: src_tick = 1'b1;
      GPTC_SRC_RISE: src_tick = ext_lvl & ~ext_d_reg;
      GPTC_SRC_FALL: src_tick = ~ext_lvl & ext_d_reg;
      GPTC_SRC_BOTH: src_tick = ext_lvl ^ ext_d_reg;
      default:       src_tick = 1'b0;
    endcase
  end

  // ==========================================================
  // match compare
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      hit[c] = (cnt_reg == MATCH_VALUE[c*W +: W]);
    end
  end

  always_comb begin
    any_reset = 1'b0;
    any_stop  = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      any_reset = any_reset | (hit[c] & MAT_CFG[c].reset);
      any_stop  = any_stop  | (hit[c] & MAT_CFG[c].stop);
    end
  end

  assign running  = CNT_ENABLE & ~stop_reg & ~CNT_RESET;
  assign pre_wrap = running & src_tick & (pre_reg == PRESCALE);

  // ==========================================================
  // prescaler
  // programmable prescaler
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pre_reg <= GPTC_PRE_RST;
    end else if (CNT_RESET) begin
      pre_reg <= GPTC_PRE_RST;
    end else if (pre_wrap) begin
      pre_reg <= GPTC_PRE_RST;
    end else if (running && src_tick) begin
      pre_reg <= pre_reg + 1'b1;
    end
  end

  // ==========================================================
  // main counter
  // advance on prescaler wrap, reset on match
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt_reg <= GPTC_CNT_RST;
    end else if (CNT_RESET) begin
      cnt_reg <= GPTC_CNT_RST;
    end else if (pre_wrap) begin
      if (any_reset) begin
        cnt_reg <= GPTC_CNT_RST;
      end else if (!any_stop) begin
        // a stopping match holds the counter at the match value
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  // stop on match, cleared by counter reset
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      stop_reg <= 1'b0;
    end else if (CNT_ENABLE && !stop_reg && any_stop) begin
      stop_reg <= 1'b1;
    end else if (CNT_RESET) begin
      stop_reg <= 1'b0;
    end
  end

  // ==========================================================
  // match events: flagged once per new counter value
  logic [W-1:0] last_cnt_reg;  // counter value already acted on
  logic         acted_reg;     // actions done for last_cnt_reg
  logic         new_val;       // first cycle with this count

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      last_cnt_reg <= GPTC_CNT_RST;
      acted_reg    <= 1'b0;
    end else begin
      last_cnt_reg <= cnt_reg;
      acted_reg    <= CNT_ENABLE;
    end
  end

  assign new_val = CNT_ENABLE & ((cnt_reg != last_cnt_reg) | ~acted_reg);

  // optional match interrupt, set wins over clear
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mirq_reg <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (new_val && hit[c] && MAT_CFG[c].irq_en) begin
          mirq_reg[c] <= 1'b1;
        end else if (MAT_IRQ_CLR[c]) begin
          mirq_reg[c] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mout_reg <= GPTC_MOUT_RST;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (new_val && hit[c]) begin
          case (MAT_CFG[c].action)
            GPTC_OUT_LOW:    mout_reg[c] <= 1'b0;
            GPTC_OUT_HIGH:   mout_reg[c] <= 1'b1;
            GPTC_OUT_TOGGLE: mout_reg[c] <= ~mout_reg[c];
            default:         mout_reg[c] <= mout_reg[c];
          endcase
        end
      end
    end
  end

  // ==========================================================
  // capture channels
  // all channels capture regardless of clock use
  for (genvar c = 0; c < NCH; c++) begin : g_cap
    gptc_cap_ch #(
      .W(W)
    ) u_cap (
      .clk      (SYS_CLK),
      .arst_n   (ARST_N),
      .sig_in   (cap_sig[c]),
      .cfg      (CAP_CFG[c]),
      .count    (cnt_reg),
      .irq_clr  (CAP_IRQ_CLR[c]),
      .value    (CAPTURE_VALUE[c*W +: W]),
      .irq_flag (CAP_IRQ_FLAG[c])
    );
  end

  // ==========================================================
  // outputs
  assign COUNT          = cnt_reg;
  assign PRESCALE_COUNT = pre_reg;
  assign MATCH_OUT      = mout_reg;
  assign MAT_IRQ_FLAG   = mirq_reg;
  assign STOPPED        = stop_reg;
  assign IRQ            = (|mirq_reg) | (|CAP_IRQ_FLAG);

endmodule : gptc_top
`default_nettype wire
